// ---- rtl/tagac_pkg.sv ----
package tagac_pkg;
   // ----------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_HANDLE = 8'h04;
   localparam logic [7:0] REG_RN16 = 8'h08;
   localparam logic [7:0] REG_ACCPWD = 8'h0c;
   localparam logic [7:0] REG_CODELO = 8'h10;
   localparam logic [7:0] REG_CODEHI = 8'h14;
   localparam logic [7:0] REG_CONFIG = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1c;
   // Configuration word fields and reset values
   localparam int CFG_ITEM_GUARD = 13;
   localparam int CFG_TAG_GUARD = 14;
   localparam int CFG_ALARM = 15;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [6:0] LINK_RESET = 7'h00;
   // ----------------------------------------
   // Command codes and frame lengths
   // ----------------------------------------
   localparam logic [15:0] CMD_GUARD_CLR = 16'he002;
   localparam logic [15:0] CMD_FLAG_UPD = 16'he003;
   localparam logic [15:0] CMD_ALARM_REQ = 16'he004;
   localparam logic [15:0] CMD_ALARM_INV = 16'h1ffb;
   localparam logic [6:0] LEN_FLAG_UPD = 7'h31;
   localparam logic [6:0] LEN_ALARM_REQ = 7'h34;
   localparam logic [6:0] LEN_GUARD_CLR = 7'h50;
   // CRC constants
   localparam logic [15:0] CRC16_PRESET = 16'hffff;
   localparam logic [15:0] CRC16_POLY = 16'h1021;
   localparam logic [15:0] CRC16_RESIDUE = 16'h1d0f;
   localparam logic [4:0] CRC5_PRESET = 5'h09;
   localparam logic [4:0] CRC5_POLY = 5'h09;
   // Reply timing and link rates
   localparam logic [6:0] DR_X3_LOW = 7'h18;
   localparam logic [6:0] DR_X3_HIGH = 7'h40;
   localparam logic [6:0] TX_LEN_HANDLE = 7'h11;
   localparam logic [6:0] TX_LEN_ERROR = 7'h19;
   localparam logic [6:0] TX_LEN_CODE = 7'h41;
   localparam logic [4:0] TX_CRC_LEN = 5'h10;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_READY = 3'b000, ST_ARB = 3'b001, ST_REPLY = 3'b010, ST_ACK = 3'b011,
      ST_OPEN = 3'b100, ST_SECURED = 3'b101, ST_KILLED = 3'b110
   } tagac_state_t;
   typedef enum logic [1:0] {
      RK_HANDLE = 2'b00, RK_ERROR = 2'b01, RK_CODE = 2'b10
   } tagac_kind_t;
   typedef enum logic [1:0] {
      CS_IDLE = 2'b00, CS_NVWAIT = 2'b01, CS_TX = 2'b10
   } tagac_cmd_t;

   // One step of the CRC-16, msb first
   function automatic logic [15:0] crc16Step(input logic [15:0] c, input logic b);
      crc16Step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC16_POLY : 16'h0000);
   endfunction

   // One step of the 5-bit CRC, msb first
   function automatic logic [4:0] crc5Step(input logic [4:0] c, input logic b);
      crc5Step = {c[3:0], 1'b0} ^ ((c[4] ^ b) ? CRC5_POLY : 5'h00);
   endfunction
endpackage

// ---- rtl/tagac_frame_rx.sv ----
`timescale 1ns/1ps
module tagac_frame_rx (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Demodulated reader bits
   input wire logic rxSof,
   input wire logic rxValid,
   input wire logic rxBit,
   input wire logic rxEof,
   // Captured frame
   output logic [79:0] frameBits,
   output logic [6:0] frameLen,
   output logic crcOk,
   output logic frameDone
);
   import tagac_pkg::*;

   logic [15:0] crc_r;

   // Shift bits in, last bit lands at bit 0; overlong frames stop counting
   always_ff @(posedge clk) begin
      if (sys_rst || rxSof) begin
         frameBits <= '0;
         frameLen <= '0;
         crc_r <= CRC16_PRESET;
      end else if (rxValid && frameLen != LEN_GUARD_CLR + 7'h01) begin
         frameBits <= {frameBits[78:0], rxBit};
         frameLen <= frameLen + 7'h01;
         crc_r <= crc16Step(crc_r, rxBit);
      end
   end

   // Check is a residue test over up to 81 received bits, CRC field included
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frameDone <= 1'b0;
         crcOk <= 1'b0;
      end else begin
         frameDone <= rxEof;
         crcOk <= (crc_r == CRC16_RESIDUE);
      end
   end
endmodule

// ---- rtl/tagac_reply_tx.sv ----
`timescale 1ns/1ps
module tagac_reply_tx #(
   parameter int BIT_DIV = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Reply request
   input wire logic start,
   input wire tagac_pkg::tagac_kind_t kind,
   input wire logic [15:0] handle,
   input wire logic [7:0] errCode,
   input wire logic [63:0] code,
   // Backscatter bit stream
   output logic txBit,
   output logic txValid,
   output logic txBusy,
   output logic [4:0] crc5
);
   import tagac_pkg::*;

   logic [64:0] sh_r;
   logic [6:0] left_r;
   logic [4:0] crcLeft_r;
   logic [15:0] crc16_r;
   logic isCode_r;
   logic first_r;
   logic [15:0] div_r;
   logic bitEn;

   // Bit-rate divider, restarted by each reply
   assign bitEn = (div_r == 16'(BIT_DIV - 1));
   always_ff @(posedge clk) begin
      if (sys_rst || start || bitEn) div_r <= '0;
      else if (txBusy) div_r <= div_r + 16'h0001;
   end

   // Payload msb first, then inverted CRC-16 where the reply has one
   always_ff @(posedge clk) begin
      txValid <= 1'b0;
      if (sys_rst) begin
         sh_r <= '0; left_r <= '0; crcLeft_r <= '0; txBusy <= 1'b0; txBit <= 1'b0;
         crc16_r <= CRC16_PRESET; crc5 <= CRC5_PRESET; isCode_r <= 1'b0; first_r <= 1'b0;
      end else if (start) begin
         unique case (kind)
            RK_HANDLE: begin
               sh_r <= {1'b0, handle, 48'h0}; left_r <= TX_LEN_HANDLE; crcLeft_r <= TX_CRC_LEN;
            end
            RK_ERROR: begin
               sh_r <= {1'b1, errCode, handle, 40'h0}; left_r <= TX_LEN_ERROR;
               crcLeft_r <= TX_CRC_LEN;
            end
            default: begin
               sh_r <= {1'b0, code}; left_r <= TX_LEN_CODE; crcLeft_r <= '0;
            end
         endcase
         crc16_r <= CRC16_PRESET;
         crc5 <= CRC5_PRESET;
         isCode_r <= (kind == RK_CODE);
         first_r <= 1'b1;
         txBusy <= 1'b1;
      end else if (txBusy && bitEn) begin
         if (left_r != 7'h00) begin
            txBit <= sh_r[64];
            txValid <= 1'b1;
            sh_r <= {sh_r[63:0], 1'b0};
            left_r <= left_r - 7'h01;
            crc16_r <= crc16Step(crc16_r, sh_r[64]);
            if (isCode_r && !first_r) crc5 <= crc5Step(crc5, sh_r[64]);
            first_r <= 1'b0;
         end else if (crcLeft_r != 5'h00) begin
            txBit <= ~crc16_r[15];
            txValid <= 1'b1;
            crc16_r <= {crc16_r[14:0], 1'b0};
            crcLeft_r <= crcLeft_r - 5'h01;
         end else begin
            txBusy <= 1'b0;
         end
      end
   end

   // Preset before the code goes out
   crc5_preset_a: assert property (@(posedge clk) disable iff (sys_rst)
      start && kind == RK_CODE |=> crc5 == CRC5_PRESET && txBusy)
      else $error("alarm code reply not started from the CRC5 preset");
endmodule

// ---- rtl/tagac_alarm_cmd.sv ----
`timescale 1ns/1ps
// What this block does
// - Guard clear in open/secured: good handle+password replies, bad password goes arbitrate.
// - Flag update only in secured; zero password, bad CRC or handle are ignored.
// - Command CRC-16 spans first command bit through last handle bit.
// - Flag update reply uses the extended preamble regardless of the round.
// - Success reply is a 0 header, the handle and CRC-16 over both.
// - A failed flag update backscatters an error code instead.
// - Flag update frame: code, set/clear bit, handle, CRC-16; tag applies it.
// - Flag set at power-up makes the tag answer alarm requests with 64-bit code.
// - Flag clear means alarm requests are ignored silently.
// - Alarm request answered in ready only; arbitrate group goes arbitrate.
// - Alarm code is returned at once, without Select or Query.
// - Alarm request: command, inverted command, divide, cycles, pilot, CRC-16.
// - Divide 0/1 gives 8 or 64/3; cycles 1,2,4,8; pilot bit adds pilot tone.
// - Alarm reply presets the 5-bit CRC to 01001b and sends 64 code bits.
// - Alarm flag is bit 15 of the stored word, kept across power-up.
// - Successful guard clear clears both memory read-guard bits.
// - Guard clear password is access password XOR the RN16 doubled.
module tagac_alarm_cmd #(
   parameter int BIT_DIV = 16,
   parameter logic [7:0] ERR_CODE = 8'h0f
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Reader bits
   input wire logic rxSof,
   input wire logic rxValid,
   input wire logic rxBit,
   input wire logic rxEof,
   // Backscatter
   output logic txBit,
   output logic txValid,
   output logic txBusy,
   output logic txExtPre,
   output logic txPilot,
   output logic [6:0] txDivX3,
   output logic [3:0] txCycles,
   // Stored configuration word
   input wire logic [15:0] nvCfgIn,
   input wire logic nvDone,
   input wire logic nvFail,
   output logic nvWrite,
   output logic [15:0] nvCfgOut,
   // Protocol state
   output tagac_pkg::tagac_state_t tagState
);
   import tagac_pkg::*;

   // ----------------------------------------
   // Registers and frame fields
   // ----------------------------------------
   logic [15:0] handle_r, rn_r, cfg_r;
   logic [31:0] accPwd_r;
   logic [63:0] code_r;
   logic [3:0] link_r;
   logic armed_r, loadPend_r, txGo_r, wrEn_r;
   logic [7:0] wrAddr_r;
   tagac_kind_t kind_r;
   tagac_cmd_t cs_r;
   tagac_state_t stNxt;
   logic [79:0] fb;
   logic [6:0] fLen;
   logic crcOk, done;
   logic [4:0] crc5;
   logic isUpd, isReq, isClr, arbGroup, pwdOk, goNv, goCode;
   logic [15:0] cfgNxt;
   logic [31:0] rdMux;

   tagac_frame_rx u_rx (
      .clk(clk), .sys_rst(sys_rst), .rxSof(rxSof), .rxValid(rxValid), .rxBit(rxBit),
      .rxEof(rxEof), .frameBits(fb), .frameLen(fLen), .crcOk(crcOk), .frameDone(done)
   );

   tagac_reply_tx #(.BIT_DIV(BIT_DIV)) u_tx (
      .clk(clk), .sys_rst(sys_rst), .start(txGo_r), .kind(kind_r), .handle(handle_r),
      .errCode(ERR_CODE), .code(code_r), .txBit(txBit), .txValid(txValid),
      .txBusy(txBusy), .crc5(crc5)
   );

   // Frames are told apart by length and leading code
   assign isUpd = done && fLen == LEN_FLAG_UPD && fb[48:33] == CMD_FLAG_UPD;
   assign isReq = done && fLen == LEN_ALARM_REQ && fb[51:36] == CMD_ALARM_REQ
                  && fb[35:20] == CMD_ALARM_INV;
   assign isClr = done && fLen == LEN_GUARD_CLR && fb[79:64] == CMD_GUARD_CLR;
   assign arbGroup = tagState == ST_ARB || tagState == ST_REPLY || tagState == ST_ACK;
   assign pwdOk = fb[63:32] == (accPwd_r ^ {rn_r, rn_r});

   // ----------------------------------------
   // Command decision
   // ----------------------------------------
   // Corrupt frames change nothing; the frame is dropped before any state check
   always_comb begin
      stNxt = tagState;
      cfgNxt = cfg_r;
      goNv = 1'b0;
      goCode = 1'b0;
      if (cs_r == CS_IDLE && crcOk) begin
         if (isReq) begin
            if (tagState == ST_READY) goCode = armed_r;
            else if (arbGroup) stNxt = ST_ARB;
         end else if (isUpd || isClr) begin
            if (arbGroup) begin
               stNxt = ST_ARB;
            end else if (isClr && (tagState == ST_OPEN || tagState == ST_SECURED)
                         && fb[31:16] == handle_r) begin
               if (pwdOk) begin
                  goNv = 1'b1;
                  cfgNxt[CFG_ITEM_GUARD] = 1'b0;
                  cfgNxt[CFG_TAG_GUARD] = 1'b0;
               end else begin
                  stNxt = ST_ARB;
               end
            end else if (isUpd && tagState == ST_SECURED && fb[31:16] == handle_r
                         && accPwd_r != 32'h0) begin
               goNv = 1'b1;
               cfgNxt[CFG_ALARM] = fb[32];
            end
         end
      end
   end

   // Command sequencer: alarm code replies at once; updates store, then reply once the store finishes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cs_r <= CS_IDLE;
         txGo_r <= 1'b0;
         kind_r <= RK_HANDLE;
      end else begin
         txGo_r <= 1'b0;
         unique case (cs_r)
            CS_IDLE: begin
               if (goNv) cs_r <= CS_NVWAIT;
               else if (goCode) begin
                  txGo_r <= 1'b1;
                  kind_r <= RK_CODE;
                  cs_r <= CS_TX;
               end
            end
            CS_NVWAIT: begin
               if (nvDone) begin
                  txGo_r <= 1'b1;
                  kind_r <= nvFail ? RK_ERROR : RK_HANDLE;
                  cs_r <= CS_TX;
               end
            end
            CS_TX: begin
               if (!txGo_r && !txBusy) cs_r <= CS_IDLE;
            end
            default: cs_r <= CS_IDLE;
         endcase
      end
   end

   // Reply link settings: extended preamble forced for handle replies
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txExtPre <= 1'b0; txPilot <= 1'b0; txDivX3 <= DR_X3_LOW; txCycles <= 4'h1;
      end else if (cs_r == CS_IDLE && goCode) begin
         txExtPre <= fb[16];
         txPilot <= fb[16];
         txDivX3 <= fb[19] ? DR_X3_HIGH : DR_X3_LOW;
         txCycles <= 4'h1 << fb[18:17];
      end else if (cs_r == CS_NVWAIT && nvDone) begin
         txExtPre <= 1'b1;
         txPilot <= 1'b1;
         txDivX3 <= link_r[1] ? DR_X3_HIGH : DR_X3_LOW;
         txCycles <= 4'h1 << link_r[3:2];
      end
   end

   // ----------------------------------------
   // Stored word: cleared to CFG_RESET by reset, reloaded from nvCfgIn after it
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         loadPend_r <= 1'b1;
         cfg_r <= CFG_RESET;
         armed_r <= 1'b0;
         nvWrite <= 1'b0;
         nvCfgOut <= CFG_RESET;
      end else begin
         nvWrite <= 1'b0;
         loadPend_r <= 1'b0;
         if (loadPend_r) begin
            cfg_r <= nvCfgIn;
            nvCfgOut <= nvCfgIn;
            armed_r <= nvCfgIn[CFG_ALARM];
         end else if (cs_r == CS_IDLE && goNv) begin
            nvCfgOut <= cfgNxt;
            nvWrite <= 1'b1;
         end else if (cs_r == CS_NVWAIT && nvDone && !nvFail) begin
            cfg_r <= nvCfgOut;
         end else if (cs_r == CS_IDLE && wrEn_r && wrAddr_r == REG_CONFIG) begin
            nvCfgOut <= hwdata[15:0];
            nvWrite <= 1'b1;
            cfg_r <= hwdata[15:0];
         end
      end
   end

   // Protocol state: a command's move wins over a software write
   always_ff @(posedge clk) begin
      if (sys_rst) tagState <= ST_READY;
      else if (stNxt != tagState) tagState <= stNxt;
      else if (wrEn_r && wrAddr_r == REG_CTRL && hwdata[2:0] != 3'b111)
         tagState <= tagac_state_t'(hwdata[2:0]);
   end

   // ----------------------------------------
   // AHB-Lite slave, zero wait, always OKAY
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrEn_r <= 1'b0; wrAddr_r <= '0; hrdata <= '0; hreadyout <= 1'b1; hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrEn_r <= hsel && htrans[1] && hready && hwrite;
         wrAddr_r <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) hrdata <= rdMux;
      end
   end

   // Read decode; unmapped words read zero
   always_comb begin
      unique case (haddr[7:0])
         REG_CTRL: rdMux = {25'h0, link_r, tagState};
         REG_HANDLE: rdMux = {16'h0, handle_r};
         REG_RN16: rdMux = {16'h0, rn_r};
         REG_ACCPWD: rdMux = accPwd_r;
         REG_CODELO: rdMux = code_r[31:0];
         REG_CODEHI: rdMux = code_r[63:32];
         REG_CONFIG: rdMux = {16'h0, cfg_r};
         REG_STATUS: rdMux = {23'h0, crc5, txBusy, armed_r, cs_r};
         default: rdMux = 32'h0;
      endcase
   end

   // Software-loaded session values
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         handle_r <= '0; rn_r <= '0; accPwd_r <= '0; code_r <= '0; link_r <= LINK_RESET[3:0];
      end else if (wrEn_r) begin
         unique case (wrAddr_r)
            REG_CTRL: link_r <= hwdata[6:3];
            REG_HANDLE: handle_r <= hwdata[15:0];
            REG_RN16: rn_r <= hwdata[15:0];
            REG_ACCPWD: accPwd_r <= hwdata;
            REG_CODELO: code_r[31:0] <= hwdata;
            REG_CODEHI: code_r[63:32] <= hwdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence reqInReady;
      cs_r == CS_IDLE && crcOk && isReq && tagState == ST_READY;
   endsequence
   sequence storeOk;
      cs_r == CS_NVWAIT && nvDone && !nvFail;
   endsequence

   alarm_reply_a: assert property (reqInReady ##0 armed_r |=>
      txGo_r && kind_r == RK_CODE ##1 txBusy)
      else $error("armed alarm request not answered");
   alarm_silent_a: assert property (reqInReady ##0 !armed_r |=>
      !txGo_r && cs_r == CS_IDLE)
      else $error("unarmed alarm request answered");
   alarm_arb_a: assert property (cs_r == CS_IDLE && crcOk && isReq && arbGroup |=>
      tagState == ST_ARB && !txGo_r)
      else $error("alarm request in arbitrate group mishandled");
   // A refused update in secured keeps its state; ready, open and killed keep theirs, the arbitrate group goes to arbitrate
   upd_ignore_a: assert property (cs_r == CS_IDLE && isUpd && tagState == ST_SECURED
      && (accPwd_r == 32'h0
      || !crcOk || fb[31:16] != handle_r) |=> !nvWrite && tagState == $past(tagState))
      else $error("invalid flag update acted on");
   flag_apply_a: assert property (storeOk ##0 nvCfgOut[CFG_ALARM] |=>
      cfg_r[CFG_ALARM] && txGo_r && kind_r == RK_HANDLE && txExtPre)
      else $error("flag set not applied or not replied");
   err_reply_a: assert property (cs_r == CS_NVWAIT && nvDone && nvFail |=>
      txGo_r && kind_r == RK_ERROR && cfg_r == $past(cfg_r))
      else $error("failed store gave no error reply");
   guard_clear_a: assert property (cs_r == CS_IDLE && crcOk && isClr && pwdOk
      && tagState == ST_SECURED && fb[31:16] == handle_r |=> nvWrite
      && !nvCfgOut[CFG_ITEM_GUARD] && !nvCfgOut[CFG_TAG_GUARD] && tagState == ST_SECURED)
      else $error("guard clear not requested");
   pwd_bad_a: assert property (cs_r == CS_IDLE && crcOk && isClr && !pwdOk
      && tagState == ST_OPEN && fb[31:16] == handle_r |=> tagState == ST_ARB && !nvWrite)
      else $error("wrong password did not fall back to arbitrate");
   rate_a: assert property (reqInReady ##0 armed_r ##0 fb[19] |=>
      txDivX3 == DR_X3_HIGH && txCycles == (4'h1 << $past(fb[18:17])))
      else $error("alarm reply link rate decoded wrongly");
endmodule

// ---- tb/tagac_reader_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Reader on the far side of the air link
// ----------------------------------------
module tagac_reader_model (
   // Clock
   input wire logic clk,
   // Reader bits towards the tag
   output logic rxSof,
   output logic rxValid,
   output logic rxBit,
   output logic rxEof,
   // Tag backscatter
   input wire logic txBit,
   input wire logic txValid
);
   logic [95:0] rep = '0;
   int repCnt = 0;
   // Quiet line before the first frame
   initial {rxSof, rxValid, rxBit, rxEof} = 4'h0;
   // Collect reply bits; a new frame forgets the old reply
   always @(posedge clk) begin
      if (rxSof) begin
         rep <= '0;
         repCnt <= 0;
      end else if (txValid) begin
         rep <= {rep[94:0], txBit};
         repCnt <= repCnt + 1;
      end
   end
   // CRC-16 over the low n bits, msb first, returned inverted
   function automatic logic [15:0] crcOf(input logic [95:0] v, input int n);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = n - 1; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
      end
      return ~c;
   endfunction
   // Send payload plus CRC; bad flips one CRC bit to provoke a refusal
   task automatic sendFrame(input logic [79:0] p, input int n, input logic bad);
      logic [95:0] f;
      f = ({16'h0, p} << 16) | {80'h0, crcOf({16'h0, p}, n) ^ {15'h0, bad}};
      @(posedge clk);
      rxSof <= 1'b1;
      for (int i = n + 15; i >= 0; i--) begin
         @(posedge clk);
         rxSof <= 1'b0;
         rxValid <= 1'b1;
         rxBit <= f[i];
         @(posedge clk);
         rxValid <= 1'b0;
         rxBit <= ~f[i];  // Gap shows no stale bit
      end
      @(posedge clk);
      rxEof <= 1'b1;
      @(posedge clk);
      rxEof <= 1'b0;
   endtask
endmodule

// ---- tb/tag_alarm_custom_commands_bench.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the alarm and guard commands
// ----------------------------------------
module tag_alarm_custom_commands_bench;
   import tagac_pkg::*;
   localparam logic [63:0] CODE = 64'h0123456789abcdef;
   localparam logic [15:0] HDL = 16'h5a3c;
   localparam logic [15:0] RN = 16'h1234;
   localparam logic [31:0] PWD = 32'h13579bdf;
   localparam logic [79:0] AREQ = {44'h0, CMD_ALARM_REQ, CMD_ALARM_INV, 4'h0};
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, nvDone = 1'b0, nvFail = 1'b0, failNext = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, rxSof, rxValid, rxBit, rxEof, txBit, txValid, txBusy;
   logic txExtPre, txPilot, nvWrite;
   logic [6:0] txDivX3;
   logic [3:0] txCycles;
   logic [15:0] nvCfgIn = 16'he000, nvCfgOut;
   tagac_state_t tagState;
   logic [4:0] c5;
   int badCount = 0, totalChecks = 0, nvWait = 0;
   // Free-running clock
   always #12.5 clk = ~clk;
   tagac_alarm_cmd #(.BIT_DIV(4)) tagac_alarm_cmd_i (
      .clk, .sys_rst(sysRst), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxSof, .rxValid, .rxBit, .rxEof,
      .txBit, .txValid, .txBusy, .txExtPre, .txPilot, .txDivX3, .txCycles, .nvCfgIn,
      .nvDone, .nvFail, .nvWrite, .nvCfgOut, .tagState);
   tagac_reader_model reader_i (.clk, .rxSof, .rxValid, .rxBit, .rxEof, .txBit, .txValid);
   // Store stub: slow answer, keeps the word unless told to fail
   always @(posedge clk) begin
      nvDone <= 1'b0;
      if (nvWrite === 1'b1) begin
         nvWait <= 3;
      end else if (nvWait > 0) begin
         nvWait <= nvWait - 1;
         nvDone <= (nvWait == 1);
         nvFail <= failNext;
         if (nvWait == 1 && !failNext) nvCfgIn <= nvCfgOut;
      end
   end
   task automatic check(input logic [95:0] got, input logic [95:0] exp);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finalReport();
      $display("Checks %0d, mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Single AHB-Lite transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check(hresp, 1'b0);
   endtask
   task automatic powerUp();
      sysRst <= 1'b1;
      repeat (3) @(posedge clk);
      sysRst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // One frame, then wait for the reply to finish and compare it
   task automatic cmd(input logic [79:0] p, input int n, input logic bad,
                      input logic [95:0] eb, input int en);
      reader_i.sendFrame(p, n, bad);
      repeat (40) @(posedge clk);
      while (txBusy !== 1'b0) @(posedge clk);
      check(reader_i.repCnt, en);
      check(reader_i.rep, eb);
   endtask
   // Expected handle reply: 0 header, handle, CRC over both
   function automatic logic [95:0] hRep();
      return {64'h0, HDL, reader_i.crcOf({80'h0, HDL}, 17)};
   endfunction
   // Watchdog well beyond the expected run
   initial begin
      #2000000;
      badCount++;
      finalReport();
   end
   initial begin
      powerUp();
      check(tagState, ST_READY);
      bus(1'b1, REG_CODELO, CODE[31:0]);
      bus(1'b1, REG_CODEHI, CODE[63:32]);
      for (int i = 0; i < 4; i++) begin
         cmd({44'h0, CMD_ALARM_REQ, CMD_ALARM_INV, i[0], i[1:0], !i[0]}, 36, 1'b0,
             {32'h0, CODE}, 65);
         check(txDivX3, i[0] ? 7'h40 : 7'h18);
         check(txCycles, 4'h1 << i[1:0]);
         check(txPilot, !i[0]);
         check(tagState, ST_READY);
      end
      c5 = 5'h09;
      for (int i = 63; i >= 0; i--) c5 = {c5[3:0], 1'b0} ^ ((c5[4] ^ CODE[i]) ? 5'h09 : 5'h00);
      bus(1'b0, REG_STATUS, 32'h0);
      check(rd[8:4], c5);
      cmd(AREQ, 36, 1'b1, 96'h0, 0);
      for (int s = 1; s < 7; s++) begin
         bus(1'b1, REG_CTRL, s);
         cmd(AREQ, 36, 1'b0, 96'h0, 0);
         check(tagState, (s < 4) ? 1 : s);
      end
      $display("Alarm request tests done");
      bus(1'b1, REG_HANDLE, {16'h0, HDL});
      bus(1'b1, REG_ACCPWD, PWD);
      for (int s = 0; s < 8; s += 2) begin
         bus(1'b1, REG_CTRL, s);
         cmd({47'h0, CMD_FLAG_UPD, 1'b1, HDL}, 33, 1'b0, 96'h0, 0);
         check(tagState, (s == 2) ? 1 : s);
      end
      bus(1'b1, REG_CTRL, 32'h5);
      cmd({47'h0, CMD_FLAG_UPD, 1'b1, HDL ^ 16'h1}, 33, 1'b0, 96'h0, 0);
      cmd({47'h0, CMD_FLAG_UPD, 1'b1, HDL}, 33, 1'b1, 96'h0, 0);
      failNext = 1'b1;
      cmd({47'h0, CMD_FLAG_UPD, 1'b1, HDL}, 33, 1'b0,
          {56'h1, 8'h0f, HDL, reader_i.crcOf({72'h1, 8'h0f, HDL}, 25)}, 41);
      failNext = 1'b0;
      cmd({47'h0, CMD_FLAG_UPD, 1'b0, HDL}, 33, 1'b0, hRep(), 33);
      check(txExtPre, 1'b1);
      check(tagState, ST_SECURED);
      bus(1'b0, REG_CONFIG, 32'h0);
      check(rd[15], 1'b0);
      cmd({47'h0, CMD_FLAG_UPD, 1'b1, HDL}, 33, 1'b0, hRep(), 33);
      bus(1'b1, REG_ACCPWD, 32'h0);
      cmd({47'h0, CMD_FLAG_UPD, 1'b0, HDL}, 33, 1'b0, 96'h0, 0);
      bus(1'b0, REG_CONFIG, 32'h0);
      check(rd[15], 1'b1);
      $display("Flag update tests done");
      bus(1'b1, REG_ACCPWD, PWD);
      bus(1'b1, REG_RN16, {16'h0, RN});
      for (int s = 4; s < 6; s++) begin
         bus(1'b1, REG_CTRL, s);
         cmd({16'h0, CMD_GUARD_CLR, PWD ^ {RN, RN}, HDL ^ 16'h1}, 64, 1'b0, 96'h0, 0);
         check(tagState, s);
         cmd({16'h0, CMD_GUARD_CLR, PWD ^ {RN, RN}, HDL}, 64, 1'b0, hRep(), 33);
         check(tagState, s);
         cmd({16'h0, CMD_GUARD_CLR, PWD ^ {RN, ~RN}, HDL}, 64, 1'b0, 96'h0, 0);
         check(tagState, ST_ARB);
      end
      bus(1'b0, REG_CONFIG, 32'h0);
      check(rd[14:13], 2'b00);
      $display("Guard clear tests done");
      bus(1'b1, REG_CTRL, 32'h5);
      cmd({47'h0, CMD_FLAG_UPD, 1'b0, HDL}, 33, 1'b0, hRep(), 33);
      powerUp();
      cmd(AREQ, 36, 1'b0, 96'h0, 0);
      $display("Power-up tests done");
      finalReport();
   end
endmodule
